// ### hw/data_space_decoder.sv
`include "data_space_regs.svh"

// Overview of operation
// - addresses 0x00-0x1F reach the 32 working registers
// - addresses 0x20-0x5F reach standard I/O space
// - extended I/O 0x60-0xFF reachable only by data loads and stores
// - SRAM starts at 0x100, top set by size option
// - direct addressing reaches the entire data space
// - displacement mode adds unsigned 0..63 to pointer a, b or c
// - pre-decrement before, post-increment after access, written back
// - pointers are register pairs 26..31
// - every SRAM access takes two clock cycles
// - eeprom read holds the cpu for four cycles
// - eeprom write holds the cpu for two cycles
// - eeprom is a separate byte-addressed space
// - self-timed write with a busy status for software
// - reset does not abort a running eeprom write
// - strobe counts only within four cycles of arming
module data_space_decoder #(
  parameter int SRAM_BYTES = 4096,
  parameter int EE_BYTES   = 4096,
  parameter int PROG_CYC   = `EE_PROG_CYC
) (
  input  wire logic                    mclk,
  input  wire logic                    sys_rst,
  // cpu data access
  input  wire logic                    acc_req,
  input  wire logic                    acc_we,
  input  wire logic                    acc_port_op,
  input  wire data_space_pkg::addr_mode_e acc_mode,
  input  wire data_space_pkg::ptr_sel_e   acc_ptr,
  input  wire logic [15:0]             acc_addr,
  input  wire logic [5:0]              acc_disp,
  input  wire logic [7:0]              acc_wdata,
  output logic [7:0]                   acc_rdata,
  output logic                         acc_done,
  output logic                         acc_fault,
  // working register operand ports
  input  wire logic [4:0]              op_rd_sel,
  output logic [7:0]                   op_rd_data,
  input  wire logic                    op_we,
  input  wire logic [4:0]              op_wr_sel,
  input  wire logic [7:0]              op_wr_data,
  // I/O target bus
  output logic                         io_sel,
  output logic                         io_ext,
  output logic                         io_we,
  output logic [7:0]                   io_addr,
  output logic [7:0]                   io_wdata,
  input  wire logic [7:0]              io_rdata,
  // eeprom control
  input  wire logic [11:0]             ee_addr,
  input  wire logic [7:0]              ee_wdata,
  input  wire logic                    ee_read_start,
  input  wire logic                    eeprom_master_write_arm,
  input  wire logic                    eeprom_write_strobe,
  output logic [7:0]                   ee_rdata,
  output logic                         ee_busy,
  output logic                         ee_arm_active,
  output logic                         cpu_hold
);
  localparam int SRAM_TOP = `SRAM_BASE + SRAM_BYTES - 1;
  localparam int SAW     = $clog2(SRAM_BYTES);
  localparam int EAW     = $clog2(EE_BYTES);
  localparam int PCW     = $clog2(PROG_CYC + 1);

  // refuse sizes that the decode and index widths cannot serve
  if (SRAM_BYTES != 1024 && SRAM_BYTES != 2048 &&
      SRAM_BYTES != 4096 && SRAM_BYTES != 16384) begin : g_bad_sram
    $error("unsupported sram size");
  end
  if (EE_BYTES < 2 || EE_BYTES > 4096 ||
      (EE_BYTES & (EE_BYTES - 1)) != 0) begin : g_bad_ee
    $error("bad eeprom size");
  end
  if (PROG_CYC < 1) begin : g_bad_prog
    $error("bad program time");
  end

  logic [7:0]  regs_q [32];
  logic [7:0]  sram_q [SRAM_BYTES];
  logic [7:0]  ee_mem_q [EE_BYTES];

  typedef enum logic [1:0] {ST_IDLE, ST_SRAM2, ST_POST} acc_state_e;
  acc_state_e  st_q;

  logic [15:0] ptr_base;
  logic [15:0] eff_addr;
  logic [15:0] ptr_wb;
  logic        ptr_upd;
  logic [4:0]  ptr_lo;
  data_space_pkg::target_e tgt;
  logic        in_map;
  logic [15:0] lat_addr_q;
  logic        lat_we_q;
  logic [7:0]  lat_wdata_q;

  // pointer pair from registers 26..31
  always_comb begin
    case (acc_ptr)
      data_space_pkg::PTR_A: ptr_lo = `PTR_A_LO;
      data_space_pkg::PTR_B: ptr_lo = `PTR_B_LO;
      data_space_pkg::PTR_C: ptr_lo = `PTR_C_LO;
      default:               ptr_lo = `PTR_C_LO;
    endcase
    ptr_base = {regs_q[ptr_lo + 5'h01], regs_q[ptr_lo]};
  end

  // effective address and pointer write-back value
  always_comb begin
    ptr_upd = 1'b0;
    ptr_wb  = ptr_base;
    case (acc_mode)
      data_space_pkg::MODE_DIRECT:   eff_addr = acc_addr;
      data_space_pkg::MODE_INDIRECT: eff_addr = ptr_base;
      data_space_pkg::MODE_DISP:
        eff_addr = ptr_base + {10'h000, acc_disp};
      data_space_pkg::MODE_PREDEC: begin
        eff_addr = ptr_base - 16'h0001;
        ptr_wb   = eff_addr;
        ptr_upd  = 1'b1;
      end
      data_space_pkg::MODE_POSTINC: begin
        eff_addr = ptr_base;
        ptr_wb   = ptr_base + 16'h0001;
        ptr_upd  = 1'b1;
      end
      default: eff_addr = acc_addr;
    endcase
  end

  // region decode
  always_comb begin
    in_map   = 1'b1;
    if (eff_addr <= `REG_FILE_TOP)
      tgt = data_space_pkg::TGT_REGS;
    else if (eff_addr <= `STD_IO_TOP)
      tgt = data_space_pkg::TGT_STD_IO;
    else if (eff_addr <= `EXT_IO_TOP)
      tgt = data_space_pkg::TGT_EXT_IO;
    else begin
      tgt    = data_space_pkg::TGT_SRAM;
      in_map = (32'(eff_addr) <= SRAM_TOP);
    end
  end

  // port-style ops may not reach extended I/O or beyond
  logic port_bad;
  assign port_bad = acc_port_op &&
                    (tgt != data_space_pkg::TGT_STD_IO);

  logic start;
  assign start = acc_req && (st_q == ST_IDLE) && !cpu_hold;

  // access sequencer, sram takes a second cycle
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q        <= ST_IDLE;
      lat_addr_q  <= 16'h0000;
      lat_we_q    <= 1'b0;
      lat_wdata_q <= 8'h00;
    end else begin
      case (st_q)
        ST_IDLE: if (start) begin
          lat_addr_q  <= eff_addr;
          // a faulted access never samples the io bus afterwards
          lat_we_q    <= acc_we || port_bad;
          lat_wdata_q <= acc_wdata;
          if (tgt == data_space_pkg::TGT_SRAM && in_map && !port_bad)
            st_q <= ST_SRAM2;
          else
            st_q <= ST_POST;
        end
        ST_SRAM2: st_q <= ST_POST;
        ST_POST:  st_q <= ST_IDLE;
        default:  st_q <= ST_IDLE;
      endcase
    end
  end

  // register file: shared by operand writes and data stores
  always_ff @(posedge mclk) begin
    if (start && ptr_upd && !port_bad) begin
      regs_q[ptr_lo]         <= ptr_wb[7:0];
      regs_q[ptr_lo + 5'h01] <= ptr_wb[15:8];
    end
    if (start && acc_we && !port_bad &&
        tgt == data_space_pkg::TGT_REGS)
      regs_q[eff_addr[4:0]] <= acc_wdata;
    else if (op_we)
      regs_q[op_wr_sel] <= op_wr_data;
  end
  assign op_rd_data = regs_q[op_rd_sel];

  // sram storage, written on the second cycle
  always_ff @(posedge mclk) begin
    if (st_q == ST_SRAM2 && lat_we_q)
      sram_q[SAW'(lat_addr_q - `SRAM_BASE)] <= lat_wdata_q;
  end

  // read data and completion
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_rdata <= 8'h00;
      acc_done  <= 1'b0;
      acc_fault <= 1'b0;
    end else begin
      acc_done  <= 1'b0;
      acc_fault <= 1'b0;
      if (start && tgt != data_space_pkg::TGT_SRAM) begin
        acc_done  <= 1'b1;
        acc_fault <= port_bad;
        if (tgt == data_space_pkg::TGT_REGS)
          acc_rdata <= regs_q[eff_addr[4:0]];
        else
          acc_rdata <= 8'h00;
      end else if (start && (!in_map || port_bad)) begin
        acc_done  <= 1'b1;
        acc_fault <= 1'b1;
        acc_rdata <= 8'h00;
      end else if (st_q == ST_SRAM2) begin
        acc_done  <= 1'b1;
        acc_rdata <= sram_q[SAW'(lat_addr_q - `SRAM_BASE)];
      end else if (st_q == ST_POST && lat_addr_q >= `STD_IO_BASE &&
                   lat_addr_q <= `EXT_IO_TOP && !lat_we_q) begin
        acc_rdata <= io_rdata;
      end
    end
  end

  // I/O strobe for one cycle
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      io_sel   <= 1'b0;
      io_ext   <= 1'b0;
      io_we    <= 1'b0;
      io_addr  <= 8'h00;
      io_wdata <= 8'h00;
    end else begin
      io_sel <= start && !port_bad &&
                (tgt == data_space_pkg::TGT_STD_IO ||
                 tgt == data_space_pkg::TGT_EXT_IO);
      io_ext   <= (tgt == data_space_pkg::TGT_EXT_IO);
      io_we    <= acc_we;
      io_addr  <= eff_addr[7:0];
      io_wdata <= acc_wdata;
    end
  end

  // arm window: strobe only counts within four cycles
  logic [2:0] arm_cnt_q;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      arm_cnt_q <= 3'h0;
    end else if (eeprom_master_write_arm) begin
      arm_cnt_q <= `ARM_WINDOW;
    end else if (arm_cnt_q != 3'h0) begin
      arm_cnt_q <= arm_cnt_q - 3'h1;
    end
  end
  assign ee_arm_active = (arm_cnt_q != 3'h0);

  logic wr_start;
  assign wr_start = eeprom_write_strobe && ee_arm_active &&
                    !ee_busy;

  // self-timed program counter; runs on through reset
  logic [PCW-1:0] prog_q;
  always_ff @(posedge mclk) begin
    if (wr_start)
      prog_q <= PCW'(PROG_CYC);
    else if (ee_busy)
      prog_q <= prog_q - 1'b1;
    else
      prog_q <= '0;
  end
  // no reset here, so power-up contents must settle to zero before use
  assign ee_busy = (prog_q != '0);

  // byte-wide eeprom array
  always_ff @(posedge mclk) begin
    if (wr_start)
      ee_mem_q[EAW'(ee_addr)] <= ee_wdata;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst)
      ee_rdata <= 8'h00;
    else if (ee_read_start && !ee_busy)
      ee_rdata <= ee_mem_q[EAW'(ee_addr)];
  end

  // cpu hold timer
  logic       hold_load;
  logic [2:0] hold_cnt;
  assign hold_load = (ee_read_start && !ee_busy) || wr_start;
  assign hold_cnt  = wr_start ? `EE_WRITE_HOLD
                              : `EE_READ_HOLD;
  hold_timer #(.WIDTH(3)) u_hold (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .load    (hold_load),
    .count   (hold_cnt),
    .busy    (cpu_hold)
  );

  sequence ee_rd_s;
    ee_read_start && !ee_busy && !wr_start;
  endsequence
  sequence hold4_s;
    cpu_hold [*4] ##1 !cpu_hold;
  endsequence

  ee_read_hold_a : assert property (@(posedge mclk) disable iff (sys_rst)
    ee_rd_s |=> hold4_s) else $error("read hold not four");
  ee_write_hold_a : assert property (@(posedge mclk) disable iff (sys_rst)
    wr_start |=> cpu_hold [*2] ##1 !cpu_hold)
    else $error("write hold not two");
  sram_two_cycle_a : assert property (@(posedge mclk) disable iff (sys_rst)
    (start && tgt == data_space_pkg::TGT_SRAM && in_map && !port_bad)
      |=> !acc_done ##1 acc_done) else $error("sram not two");
  arm_window_a : assert property (@(posedge mclk) disable iff (sys_rst)
    eeprom_master_write_arm ##1 !eeprom_master_write_arm [*4]
      |=> !ee_arm_active) else $error("arm did not expire");
  ext_io_port_a : assert property (@(posedge mclk) disable iff (sys_rst)
    (start && acc_port_op && tgt == data_space_pkg::TGT_EXT_IO)
      |=> !io_sel && acc_fault) else $error("port reached ext io");
  std_io_route_a : assert property (@(posedge mclk) disable iff (sys_rst)
    (start && tgt == data_space_pkg::TGT_STD_IO)
      |=> io_sel && !io_ext) else $error("std io not routed");
  ee_busy_start_a : assert property (@(posedge mclk) disable iff (sys_rst)
    wr_start |=> ee_busy [*3]) else $error("write not busy");
  reg_done_a : assert property (@(posedge mclk) disable iff (sys_rst)
    (start && tgt == data_space_pkg::TGT_REGS)
      |=> acc_done && !io_sel) else $error("reg access wrong");
endmodule : data_space_decoder

// ### hw/data_space_regs.svh
`ifndef DATA_SPACE_REGS_SVH
`define DATA_SPACE_REGS_SVH

// data space map
`define REG_FILE_BASE   16'h0000
`define REG_FILE_TOP    16'h001F
`define STD_IO_BASE     16'h0020
`define STD_IO_TOP      16'h005F
`define EXT_IO_BASE     16'h0060
`define EXT_IO_TOP      16'h00FF
`define SRAM_BASE       16'h0100
// pointer register indices
`define PTR_A_LO        5'h1A
`define PTR_B_LO        5'h1C
`define PTR_C_LO        5'h1E
// cpu hold lengths and arm window in cycles, displacement limit
`define EE_READ_HOLD    3'h4
`define EE_WRITE_HOLD   3'h2
`define ARM_WINDOW      3'h4
`define DISP_MAX        6'h3F
// eeprom programming time, 3.4 ms at 25 ns
`define EE_PROG_NS      3400000
`define EE_PROG_CYC     (`EE_PROG_NS / 25)

`endif

// ### hw/data_space_pkg.sv
package data_space_pkg;
  // addressing mode of a data access
  typedef enum logic [2:0] {
    MODE_DIRECT,
    MODE_INDIRECT,
    MODE_DISP,
    MODE_PREDEC,
    MODE_POSTINC
  } addr_mode_e;
  // pointer selection
  typedef enum logic [1:0] {
    PTR_A,
    PTR_B,
    PTR_C
  } ptr_sel_e;
  // decoded target
  typedef enum logic [1:0] {
    TGT_REGS,
    TGT_STD_IO,
    TGT_EXT_IO,
    TGT_SRAM
  } target_e;
endpackage : data_space_pkg

// ### hw/hold_timer.sv
`include "data_space_regs.svh"

// down counter that reports busy while nonzero
module hold_timer #(
  parameter int WIDTH = 3
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] count,
  output logic                  busy
);
  logic [WIDTH-1:0] cnt_q;

  // a zero-width counter could never hold
  if (WIDTH < 1) begin : g_bad_width
    $error("hold_timer width too small");
  end

  // load wins over countdown so back to back holds chain
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= count;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign busy = (cnt_q != '0);
endmodule : hold_timer

// ### test/io_target_model.sv
module io_target_model (
  input  wire logic       mclk,
  input  wire logic       io_sel,
  input  wire logic       io_we,
  input  wire logic [7:0] io_addr,
  input  wire logic [7:0] io_wdata,
  output logic      [7:0] io_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem_q [256];
  logic [7:0] junk_q = 8'h5A;
  // stores land on a write select
  always @(posedge mclk) begin
    if (io_sel && io_we) begin
      mem_q[io_addr] <= io_wdata;
    end
  end
  // toggles so stale bus data can never pass for an answer
  always @(posedge mclk) begin
    junk_q <= ~junk_q;
  end
  // answer while selected, sampled by the decoder the next edge
  assign io_rdata = (io_sel && !io_we) ? mem_q[io_addr] : junk_q;
endmodule : io_target_model

// ### test/data_space_decoder_tb.sv
module data_space_decoder_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PROG = 10;
  typedef struct packed {
    logic [7:0] v;
    logic       ld;
    logic       late;
    logic       flt;
  } exp_s;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        acc_req = 1'b0;
  logic        acc_we = 1'b0;
  logic        acc_port_op = 1'b0;
  logic [15:0] acc_addr = 16'h0000;
  logic [5:0]  acc_disp = 6'h00;
  logic [7:0]  acc_wdata = 8'h00;
  logic [4:0]  op_rd_sel = 5'h00;
  logic        op_we = 1'b0;
  logic [4:0]  op_wr_sel = 5'h00;
  logic [7:0]  op_wr_data = 8'h00;
  logic [11:0] ee_addr = 12'h000;
  logic [7:0]  ee_wdata = 8'h00;
  logic        ee_read_start = 1'b0;
  logic        arm = 1'b0;
  logic        strobe = 1'b0;
  logic [7:0]  acc_rdata, op_rd_data, io_addr, io_wdata, io_rdata;
  logic [7:0]  ee_rdata, d0, d1;
  logic        acc_done, acc_fault, io_sel, io_ext, io_we;
  logic        ee_busy, ee_arm_active, cpu_hold, pend, ext_seen;
  logic [7:0]  addr_seen;
  data_space_pkg::addr_mode_e acc_mode = data_space_pkg::MODE_DIRECT;
  data_space_pkg::ptr_sel_e   acc_ptr = data_space_pkg::PTR_A;
  exp_s        q[$];
  exp_s        p;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          lat, n;

  data_space_decoder #(.PROG_CYC(PROG)) data_space_decoder_inst (
    .mclk(mclk), .sys_rst(sys_rst), .acc_req(acc_req), .acc_we(acc_we),
    .acc_port_op(acc_port_op), .acc_mode(acc_mode), .acc_ptr(acc_ptr),
    .acc_addr(acc_addr), .acc_disp(acc_disp), .acc_wdata(acc_wdata),
    .acc_rdata(acc_rdata), .acc_done(acc_done), .acc_fault(acc_fault),
    .op_rd_sel(op_rd_sel), .op_rd_data(op_rd_data), .op_we(op_we),
    .op_wr_sel(op_wr_sel), .op_wr_data(op_wr_data), .io_sel(io_sel),
    .io_ext(io_ext), .io_we(io_we), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .ee_addr(ee_addr),
    .ee_wdata(ee_wdata), .ee_read_start(ee_read_start),
    .eeprom_master_write_arm(arm), .eeprom_write_strobe(strobe),
    .ee_rdata(ee_rdata), .ee_busy(ee_busy),
    .ee_arm_active(ee_arm_active), .cpu_hold(cpu_hold));
  io_target_model io_target_model_inst (
    .mclk(mclk), .io_sel(io_sel), .io_we(io_we), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_rdata(io_rdata));

  always #12.5 mclk = ~mclk;

  task automatic chk(input string nm, input logic [15:0] e, s);
    samples_checked++;
    if (e !== s) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
      n_fail++;
    end
  endtask : chk

  task automatic wrap_up();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  // one-edge request, then wait for done under a bound
  task automatic go(input logic [15:0] a, input logic w, input logic [7:0] d,
                    input logic f, input logic l);
    q.push_back('{d, !w && !f, l, f});
    @(posedge mclk);
    #1;
    acc_addr = a;
    acc_we = w;
    acc_wdata = d;
    acc_req = 1'b1;
    @(posedge mclk);
    #1;
    acc_req = 1'b0;
    // the taking edge is the first cycle of the access
    lat = 1;
    while (acc_done !== 1'b1 && lat < 10) begin
      @(posedge mclk);
      #1;
      lat++;
    end
    if (acc_done !== 1'b1) begin
      $display("[FAIL] acc_done expected 1 seen %b", acc_done);
      n_fail++;
    end
    repeat (2) @(posedge mclk);
    #1;
  endtask : go

  task automatic wreg(input logic [4:0] s, input logic [7:0] v);
    @(posedge mclk);
    #1;
    op_we = 1'b1;
    op_wr_sel = s;
    op_wr_data = v;
    @(posedge mclk);
    #1;
    op_we = 1'b0;
  endtask : wreg

  task automatic rreg(input logic [4:0] s, input logic [7:0] v);
    op_rd_sel = s;
    #1;
    chk("op_rd_data", v, op_rd_data);
  endtask : rreg

  task automatic pulse(input int k);
    @(posedge mclk);
    #1;
    ee_read_start = (k == 0);
    arm = (k == 1);
    strobe = (k == 2);
    @(posedge mclk);
    #1;
    {ee_read_start, arm, strobe} = 3'h0;
  endtask : pulse

  task automatic hold_cnt(input int e);
    n = 0;
    repeat (8) begin
      @(negedge mclk);
      if (cpu_hold === 1'b1) n++;
    end
    chk("cpu_hold cycles", e, n);
  endtask : hold_cnt

  task automatic ee_wr(input logic [11:0] a, input logic [7:0] d, int k);
    ee_addr = a;
    ee_wdata = d;
    pulse(1);
    repeat (k) @(posedge mclk);
    pulse(2);
  endtask : ee_wr

  task automatic ee_done();
    n = 0;
    while (ee_busy === 1'b1 && n < PROG + 20) begin
      @(posedge mclk);
      n++;
    end
    #1;
    chk("ee_busy", 0, ee_busy);
  endtask : ee_done

  task automatic ee_rd(input logic [11:0] a, input logic [7:0] d);
    ee_addr = a;
    pulse(0);
    hold_cnt(4);
    chk("ee_rdata", d, ee_rdata);
  endtask : ee_rd

  // scoreboard: oldest note against each answer
  always @(negedge mclk) begin
    if (pend) chk("acc_rdata", p.v, acc_rdata);
    pend = 1'b0;
    if (io_sel === 1'b1) {ext_seen, addr_seen} = {io_ext, io_addr};
    if (acc_done === 1'b1 && q.size() > 0) begin
      p = q.pop_front();
      chk("acc_fault", p.flt, acc_fault);
      if (p.ld && p.late) pend = 1'b1;
      else if (p.ld) chk("acc_rdata", p.v, acc_rdata);
    end else if (acc_done === 1'b1) begin
      $display("[FAIL] acc_done expected 0 seen 1");
      n_fail++;
    end
  end

  // hang guard, generous for the short programming time
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 20000) begin
      $display("[FAIL] cycle limit expected %0d seen %0d", 20000, cyc);
      n_fail++;
      wrap_up();
    end
  end

  initial begin
    pend = 1'b0;
    d0 = 8'($urandom(32'hDC16));
    // forced apart so a stale byte cannot pass for the new one
    d1 = d0 ^ (8'($urandom) | 8'h01);
    repeat (16) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    go(16'h0005, 1, d0, 0, 0);
    rreg(5'h05, d0);
    wreg(5'h07, d1);
    go(16'h0007, 0, d1, 0, 0);
    go(16'h0025, 1, d1, 0, 0);
    chk("io_addr", 8'h25, {ext_seen, addr_seen[6:0]});
    go(16'h0025, 0, d1, 0, 1);
    go(16'h0070, 1, d0, 0, 0);
    chk("io_ext", 1, ext_seen);
    acc_port_op = 1'b1;
    go(16'h0030, 1, d0, 0, 0);
    go(16'h0070, 0, d0, 1, 0);
    acc_port_op = 1'b0;
    go(16'h0100, 1, d0, 0, 0);
    chk("sram latency", 2, lat);
    go(16'h10FF, 1, d1, 0, 0);
    go(16'h0100, 0, d0, 0, 0);
    chk("sram latency", 2, lat);
    go(16'h10FF, 0, d1, 0, 0);
    go(16'h1100, 0, d1, 1, 0);
    wreg(5'h1C, 8'h20);
    wreg(5'h1D, 8'h01);
    acc_mode = data_space_pkg::MODE_DISP;
    acc_ptr = data_space_pkg::PTR_B;
    acc_disp = 6'h3F;
    go(16'h0000, 1, d1, 0, 0);
    acc_mode = data_space_pkg::MODE_DIRECT;
    go(16'h015F, 0, d1, 0, 0);
    wreg(5'h1A, 8'hFF);
    wreg(5'h1B, 8'h01);
    acc_mode = data_space_pkg::MODE_POSTINC;
    acc_ptr = data_space_pkg::PTR_A;
    go(16'h0000, 1, d0, 0, 0);
    rreg(5'h1A, 8'h00);
    rreg(5'h1B, 8'h02);
    acc_mode = data_space_pkg::MODE_PREDEC;
    acc_ptr = data_space_pkg::PTR_C;
    wreg(5'h1E, 8'h00);
    wreg(5'h1F, 8'h02);
    go(16'h0000, 0, d0, 0, 0);
    rreg(5'h1E, 8'hFF);
    rreg(5'h1F, 8'h01);
    acc_mode = data_space_pkg::MODE_INDIRECT;
    go(16'h0000, 0, d0, 0, 0);
    acc_mode = data_space_pkg::MODE_DIRECT;
    // strobe early, then on the last edge of the window
    for (int i = 0; i < 2; i++) begin
      ee_wr(12'(i * 12'hFFF), i ? d1 : d0, 2 * i);
      chk("ee_busy", 1, ee_busy);
      hold_cnt(2);
      ee_done();
    end
    ee_rd(12'h000, d0);
    ee_rd(12'hFFF, d1);
    // one edge past the window, so the strobe must be refused
    ee_wr(12'h000, d1, 3);
    @(negedge mclk);
    chk("late strobe", 0, {ee_busy, ee_arm_active});
    ee_wr(12'h010, d1, 0);
    #1;
    sys_rst = 1'b1;
    @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    chk("ee_busy", 1, ee_busy);
    ee_done();
    ee_rd(12'h010, d1);
    ee_rd(12'h000, d0);
    wrap_up();
  end
endmodule : data_space_decoder_tb
